//--- pkg/cifc_pkg.sv
// constants and types for the processor interrupt flag control block
//
// Summary of operation
// - maskable requests blocked while enable flag is 0, admitted while 1
// - taking an interrupt acknowledge clears the enable flag to 0
// - stack select 0 picks interrupt stack pointer, 1 picks user stack pointer
// - stack select cleared on hardware acknowledge and software interrupt 0 to 31
// - low level on reset input resets the whole block
// - every port pin has its own direction bit
// - input pins have a software-controlled pull-up enable
// - request admitted only when its level is strictly above the 3-bit threshold
package cifc_pkg;
    localparam int PRIO_W = 3;
    localparam int VEC_W = 6;
    localparam int PORT_PINS = 12;
    localparam logic [VEC_W-1:0] SW_VEC_MAX = 6'h1F;
    localparam logic IEN_RST = 1'b0;
    localparam logic SSEL_RST = 1'b0;
    localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
    localparam logic SSEL_ISP = 1'b0;
    localparam logic SSEL_USP = 1'b1;
    typedef logic [PRIO_W-1:0] cifc_prio_t;
    typedef logic [VEC_W-1:0] cifc_vec_t;
endpackage

//--- logic/cifc_flag_ctrl.sv
// interrupt enable, stack select and priority gate with port pin control
`timescale 1ns/1ps
`default_nettype none
module cifc_flag_ctrl
#(
    parameter int PINS = cifc_pkg::PORT_PINS
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ien_set,
    input wire logic ien_clr,
    input wire logic ssel_set,
    input wire logic ssel_clr,
    input wire logic prio_wr,
    input wire cifc_pkg::cifc_prio_t prio_wdata,
    input wire logic irq_req,
    input wire cifc_pkg::cifc_prio_t irq_level,
    input wire logic hw_ack,
    input wire logic sw_int,
    input wire cifc_pkg::cifc_vec_t sw_vec,
    input wire logic [PINS-1:0] dir_wdata,
    input wire logic dir_wr,
    input wire logic [PINS-1:0] pull_wdata,
    input wire logic pull_wr,
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] port_wdata,
    input wire logic port_wr,
    output logic ien,
    output logic ssel,
    output cifc_pkg::cifc_prio_t cpu_priority_threshold,
    output logic irq_take,
    output logic sp_is_user_stack_pointer,
    output logic sp_is_irq_stack_pointer,
    output logic saved_ien,
    output logic saved_ssel,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pull_en,
    output logic [PINS-1:0] port_rdata
);
    import cifc_pkg::*;

    // ----------------------------------------
    // flag state
    // ----------------------------------------
    logic ien_r, ien_nxt, ssel_r, ssel_nxt;
    logic sv_ien_r, sv_ien_nxt, sv_ssel_r, sv_ssel_nxt;
    logic take_r, take_nxt;
    logic irq_sp_r, irq_sp_nxt;
    logic [PRIO_W-1:0] prio_r, prio_nxt;
    logic ssel_hit;

    always_comb
    begin
        ien_nxt = ien_r;
        ssel_nxt = ssel_r;
        prio_nxt = prio_r;
        sv_ien_nxt = sv_ien_r;
        sv_ssel_nxt = sv_ssel_r;
        if (ien_set)
            ien_nxt = 1'b1;
        if (ien_clr)
            ien_nxt = 1'b0;
        if (ssel_set)
            ssel_nxt = 1'b1;
        if (ssel_clr)
            ssel_nxt = 1'b0;
        if (prio_wr)
            prio_nxt = prio_wdata;
        ssel_hit = hw_ack || (sw_int && sw_vec <= SW_VEC_MAX);
        if (hw_ack || sw_int)
        begin
            sv_ien_nxt = ien_r;
            sv_ssel_nxt = ssel_r;
        end
        // acknowledge wins over software set
        if (hw_ack || sw_int)
            ien_nxt = 1'b0;
        if (ssel_hit)
            ssel_nxt = 1'b0;
        irq_sp_nxt = ~ssel_nxt;
        take_nxt = irq_req && ien_r && !hw_ack && (irq_level > prio_r);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ien_r <= IEN_RST;
            ssel_r <= SSEL_RST;
            prio_r <= PRIO_RST;
            sv_ien_r <= IEN_RST;
            sv_ssel_r <= SSEL_RST;
            take_r <= 1'b0;
            irq_sp_r <= ~SSEL_RST;
        end
        else
        begin
            ien_r <= ien_nxt;
            ssel_r <= ssel_nxt;
            prio_r <= prio_nxt;
            sv_ien_r <= sv_ien_nxt;
            sv_ssel_r <= sv_ssel_nxt;
            take_r <= take_nxt;
            irq_sp_r <= irq_sp_nxt;
        end
    end

    // ----------------------------------------
    // port pins
    // ----------------------------------------
    logic [PINS-1:0] dir_r, dir_nxt, pull_r, pull_nxt, dout_r, dout_nxt, din_r, din_nxt;
    logic [PINS-1:0] pen_r, pen_nxt;

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            always_comb
            begin
                dir_nxt[g] = dir_wr ? dir_wdata[g] : dir_r[g];
                pull_nxt[g] = pull_wr ? pull_wdata[g] : pull_r[g];
                dout_nxt[g] = port_wr ? port_wdata[g] : dout_r[g];
                din_nxt[g] = dir_r[g] ? dout_r[g] : pin_in[g];
                pen_nxt[g] = pull_nxt[g] & ~dir_nxt[g];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dir_r <= '0;
            pull_r <= '0;
            dout_r <= '0;
            din_r <= '0;
            pen_r <= '0;
        end
        else
        begin
            dir_r <= dir_nxt;
            pull_r <= pull_nxt;
            dout_r <= dout_nxt;
            din_r <= din_nxt;
            pen_r <= pen_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign ien = ien_r;
    assign ssel = ssel_r;
    assign cpu_priority_threshold = prio_r;
    assign irq_take = take_r;
    assign sp_is_user_stack_pointer = ssel_r;
    assign sp_is_irq_stack_pointer = irq_sp_r;
    assign saved_ien = sv_ien_r;
    assign saved_ssel = sv_ssel_r;
    assign pin_out = dout_r;
    assign pin_oe = dir_r;
    assign pull_en = pen_r;
    assign port_rdata = din_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_ack;
        hw_ack || sw_int;
    endsequence

    a_ack_clears_ien: assert property (@(posedge clk) disable iff (!rst_n)
        s_ack |=> !ien)
        else $error("enable flag not cleared by acknowledge");
    a_ack_clears_ssel: assert property (@(posedge clk) disable iff (!rst_n)
        (hw_ack || (sw_int && sw_vec <= SW_VEC_MAX)) |=> !ssel)
        else $error("stack select not cleared");
    a_high_vec_keep: assert property (@(posedge clk) disable iff (!rst_n)
        (sw_int && !hw_ack && sw_vec > SW_VEC_MAX && !ssel_set && !ssel_clr) |=> $stable(ssel))
        else $error("stack select changed on high vector");
    a_masked_block: assert property (@(posedge clk) disable iff (!rst_n)
        !ien |=> !irq_take)
        else $error("request taken while disabled");
    a_prio_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_req && irq_level <= cpu_priority_threshold) |=> !irq_take)
        else $error("request at or below threshold taken");
    a_prio_admit: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_req && ien && !hw_ack && irq_level > cpu_priority_threshold) |=> irq_take)
        else $error("eligible request not taken");
    a_save_flags: assert property (@(posedge clk) disable iff (!rst_n)
        s_ack |=> (saved_ien == $past(ien) && saved_ssel == $past(ssel)))
        else $error("flags not saved on acknowledge");
    a_stack_sel: assert property (@(posedge clk) disable iff (!rst_n)
        sp_is_user_stack_pointer != sp_is_irq_stack_pointer)
        else $error("stack pointer choice inconsistent");
    a_reset_flags: assert property (@(posedge clk)
        !rst_n |=> (!ien && !ssel && pin_oe == '0))
        else $error("reset did not clear state");
    a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
        dir_wr |=> pin_oe == $past(dir_wdata))
        else $error("direction write lost");
    a_pull_input: assert property (@(posedge clk) disable iff (!rst_n)
        (pull_en & pin_oe) == '0)
        else $error("pull-up active on output pin");

    sequence s_soft_ien;
        ien_set && !ien_clr && !hw_ack && !sw_int;
    endsequence
    a_ien_soft_set: assert property (@(posedge clk) disable iff (!rst_n)
        s_soft_ien |=> ien)
        else $error("software set of enable flag lost");
    a_ssel_soft_set: assert property (@(posedge clk) disable iff (!rst_n)
        (ssel_set && !ssel_clr && !hw_ack && !sw_int) |=> ssel)
        else $error("software set of stack select lost");
    a_pull_write: assert property (@(posedge clk) disable iff (!rst_n)
        pull_wr |=> pull_en == ($past(pull_wdata) & ~pin_oe))
        else $error("pull-up write lost");
    a_prio_write: assert property (@(posedge clk) disable iff (!rst_n)
        prio_wr |=> cpu_priority_threshold == $past(prio_wdata))
        else $error("threshold write lost");
    a_reset_pins: assert property (@(posedge clk)
        !rst_n |=> (sp_is_irq_stack_pointer && pull_en == '0 && !irq_take))
        else $error("reset did not set outputs");
endmodule
`default_nettype wire

//--- tb/cifc_src.sv
// request source and sequencer model for the flag control bench
`timescale 1ns/1ps
`default_nettype none
module cifc_src
(
    input wire logic clk,
    input wire logic en,
    output logic irq_req,
    output cifc_pkg::cifc_prio_t irq_level,
    output logic hw_ack,
    output logic sw_int,
    output cifc_pkg::cifc_vec_t sw_vec
);
    import cifc_pkg::*;
    // requests only while out of reset, sparse acknowledges
    always @(negedge clk)
    begin
        irq_req <= en && ($urandom % 2);
        irq_level <= cifc_prio_t'($urandom);
        hw_ack <= en && ($urandom % 8) == 0;
        sw_int <= en && ($urandom % 8) == 0;
        sw_vec <= cifc_vec_t'($urandom);
    end
endmodule
`default_nettype wire

//--- tb/test_cifc_flag_ctrl.sv
// self-checking bench for the interrupt flag control block
`timescale 1ns/1ps
`default_nettype none
module test_cifc_flag_ctrl;
    import cifc_pkg::*;
    localparam int P = PORT_PINS;
    logic clk = 0, rst_n = 0, ien_set = 0, ien_clr = 0, ssel_set = 0, ssel_clr = 0;
    logic prio_wr = 0, dir_wr = 0, pull_wr = 0, port_wr = 0, irq_req, hw_ack, sw_int;
    logic ien, ssel, irq_take, spu, spi, saved_ien, saved_ssel, m_ien, m_ssel, m_take, m_si, m_ss;
    cifc_prio_t prio_wdata = '0, irq_level, cpu_priority_threshold;
    cifc_vec_t sw_vec;
    logic [P-1:0] dir_wdata = '0, pull_wdata = '0, pin_in = '0, port_wdata = '0;
    logic [P-1:0] pin_out, pin_oe, pull_en, port_rdata, m_dir, m_pull, m_out, m_rd;
    int m_thr, n_fail = 0, total_checks = 0;
    always #10 clk = ~clk;
    cifc_src u_cifc_src (.clk(clk), .en(rst_n), .irq_req(irq_req), .irq_level(irq_level),
        .hw_ack(hw_ack), .sw_int(sw_int), .sw_vec(sw_vec));
    cifc_flag_ctrl #(.PINS(P)) u_cifc_flag_ctrl (.clk(clk), .rst_n(rst_n), .ien_set(ien_set),
        .ien_clr(ien_clr), .ssel_set(ssel_set), .ssel_clr(ssel_clr), .prio_wr(prio_wr),
        .prio_wdata(prio_wdata), .irq_req(irq_req), .irq_level(irq_level), .hw_ack(hw_ack),
        .sw_int(sw_int), .sw_vec(sw_vec), .dir_wdata(dir_wdata), .dir_wr(dir_wr),
        .pull_wdata(pull_wdata), .pull_wr(pull_wr), .pin_in(pin_in), .port_wdata(port_wdata),
        .port_wr(port_wr), .ien(ien), .ssel(ssel), .cpu_priority_threshold(cpu_priority_threshold),
        .irq_take(irq_take), .sp_is_user_stack_pointer(spu), .sp_is_irq_stack_pointer(spi),
        .saved_ien(saved_ien), .saved_ssel(saved_ssel), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_en(pull_en), .port_rdata(port_rdata));
    // ----------------------------------------
    // reference model
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            {m_ien, m_ssel, m_take, m_si, m_ss, m_dir, m_pull, m_out, m_rd} = '0;
            m_thr = 0;
        end
        else
        begin
            m_take = irq_req && m_ien && (int'(irq_level) > m_thr) && !hw_ack;
            if (hw_ack || sw_int)
            begin
                m_si = m_ien;
                m_ss = m_ssel;
            end
            m_rd = (m_dir & m_out) | (~m_dir & pin_in);
            if (ien_set) m_ien = 1'b1;
            if (ien_clr || hw_ack || sw_int) m_ien = 1'b0;
            if (ssel_set) m_ssel = 1'b1;
            if (ssel_clr || hw_ack || (sw_int && sw_vec <= SW_VEC_MAX)) m_ssel = 1'b0;
            if (prio_wr) m_thr = int'(prio_wdata);
            if (dir_wr) m_dir = dir_wdata;
            if (pull_wr) m_pull = pull_wdata;
            if (port_wr) m_out = port_wdata;
        end
    end
    // ----------------------------------------
    // checks and closing
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic r(input int n);
        return ($urandom % n) == 0;
    endfunction
    initial
    begin
        #100000;
        n_fail++;
        results;
    end
    initial
    begin
        void'($urandom(32'h8F2A));
        for (int t = 0; t < 2; t++)
        begin
            rst_n <= 1'b0;
            repeat (3) @(negedge clk);
            rst_n <= 1'b1;
            repeat (2000)
            begin
                @(negedge clk);
                chk(32'({ien, saved_ien, irq_take}), 32'({m_ien, m_si, m_take}));
                chk(32'({ssel, saved_ssel, spu, spi}), 32'({m_ssel, m_ss, m_ssel, !m_ssel}));
                chk(32'(cpu_priority_threshold), 32'(m_thr));
                chk(32'({pin_oe, pin_out}), 32'({m_dir, m_out}));
                chk(32'({pull_en, port_rdata}), 32'({m_pull & ~m_dir, m_rd}));
                {ien_set, ssel_set, prio_wr} <= {r(4), r(4), r(8)};
                {ien_clr, ssel_clr, dir_wr, pull_wr, port_wr} <= {r(8), r(8), r(8), r(8), r(8)};
                prio_wdata <= cifc_prio_t'($urandom);
                {dir_wdata, pull_wdata} <= {P'($urandom), P'($urandom)};
                {pin_in, port_wdata} <= {P'($urandom), P'($urandom)};
            end
            $display("test %0d done", t);
        end
        results;
    end
endmodule
`default_nettype wire
